// File: shared/adc_link_pkg.sv
package adc_link_pkg;

    // ==========================================================
    // Conversion frame geometry
    // ==========================================================
    localparam int RES_W = 10;
    localparam int CTRL_W = 8;
    localparam logic [4:0] CONV_SLOTS = 5'h10;
    localparam logic [4:0] TRACK_LAST = 5'h03;
    localparam logic [4:0] HOLD_FIRST = 5'h04;
    localparam logic [4:0] RES_FIRST = 5'h05;
    localparam logic [4:0] RES_LAST = 5'h0e;
    localparam logic [4:0] CTRL_RISES = 5'h08;
    localparam int CHAN_B0_POS = 3;
    localparam int CHAN_B1_POS = 4;
    localparam int CHAN_B2_POS = 5;
    localparam logic CHAN_RESET = 1'b0;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // ==========================================================
    // Host shift clock timing
    // ==========================================================
    localparam int MCLK_NS = 50;
    localparam int SCLK_MAX_KHZ = 8000;
    localparam int SCLK_HALF_NS = 200;
    localparam int HALF_CYC = (SCLK_HALF_NS + MCLK_NS - 1) / MCLK_NS;
    localparam logic [2:0] HALF_LAST = 3'(HALF_CYC - 1);

    // ==========================================================
    // Host register map
    // ==========================================================
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h1;
    localparam logic [3:0] REG_RESULT = 4'h2;
    localparam int CTRL_START_POS = 0;
    localparam int CTRL_CHAN_POS = 1;
    localparam int CTRL_NCONV_LSB = 2;
    localparam int NCONV_W = 4;
    localparam int STAT_BUSY_POS = 0;
    localparam int STAT_VALID_POS = 1;
    localparam int STAT_CHAN_POS = 2;

endpackage

// File: shared/adc_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface adc_link_if;
    logic cs_n;
    logic sclk;
    logic din;
    logic dout;
    logic dout_oe;
    logic dout_seen;

    // Weak pull-up stands in for the released line
    assign dout_seen = dout_oe ? dout : 1'b1;

    modport host (output cs_n, output sclk, output din, input dout_seen);
    modport device (input cs_n, input sclk, input din, output dout, output dout_oe);
endinterface
`default_nettype wire

// File: rtl/sync_edge.sv
`timescale 1ns/10ps
`default_nettype none
module sync_edge #(
    parameter logic INIT = 1'b0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic d,
    output logic q,
    output logic rise,
    output logic fall
);
    logic meta;
    logic q_d;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= INIT;
            q <= INIT;
            q_d <= INIT;
        end else begin
            meta <= d;
            q <= meta;
            q_d <= q;
        end
    end

    assign rise = q && !q_d;
    assign fall = !q && q_d;
endmodule
`default_nettype wire

// File: rtl/adc_frame_device.sv
// Functional notes
// RULE1: first three clocks track the selected input
// RULE2: remaining thirteen clocks hold and convert; HOLD here covers clocks 4 to 15 only, clock 16 is POWER_DOWN
// RULE3: result MSB first from fifth clock
// RULE4: host frames with 16N rising edges
// RULE5: output driven only while select low
// RULE6: power down when deselected or between conversions
// RULE7: retrack after 16Nth rise, hold N*16+4
// RULE8: shift clock ignored while deselected
// RULE9: select fall with clock low counts falling
// RULE10: clock high waits first real fall
// RULE11: control bits captured first eight rises
// RULE12: channel code applies to next conversion
// RULE13: don't-care control bits have no effect
// RULE14: bits five to three form channel field
// RULE15: low address bit picks input; middle forbidden
// RULE16: first input selected after reset
// RULE17: valid conversion from first frame
// RULE18: ten-bit straight binary result
// RULE19: host respects select to clock margins
// RULE20: output changes after fall, sampled rise
// RULE21: shift clock no faster than 8 MHz
// RULE22: zeros in lead and tail slots
// RULE23: host assembles result from slot positions
`timescale 1ns/10ps
`default_nettype none
module adc_frame_device (
    input wire logic MCLK,
    input wire logic RST_N,
    adc_link_if.device LINK,
    input wire logic [9:0] ANALOG_A,
    input wire logic [9:0] ANALOG_B,
    output logic TRACK,
    output logic HOLD,
    output logic POWER_DOWN,
    output logic CHANNEL,
    output logic [7:0] CTRL_WORD,
    output logic ADDR_FAULT,
    output logic [9:0] RESULT,
    output logic RESULT_VALID,
    output logic FRAME_ERROR
);

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    logic cs_s;
    logic cs_fall;
    logic cs_rise;
    logic sclk_s;
    logic sclk_rise;
    logic sclk_fall;
    logic din_s;

    sync_edge #(.INIT(1'b1)) u_cs (
        .clk(MCLK),
        .rst_n(RST_N),
        .d(LINK.cs_n),
        .q(cs_s),
        .rise(cs_rise),
        .fall(cs_fall)
    );

    // Clock rests high, so a low start value would fake an edge after reset
    sync_edge #(.INIT(1'b1)) u_sclk (
        .clk(MCLK),
        .rst_n(RST_N),
        .d(LINK.sclk),
        .q(sclk_s),
        .rise(sclk_rise),
        .fall(sclk_fall)
    );

    sync_edge #(.INIT(1'b0)) u_din (
        .clk(MCLK),
        .rst_n(RST_N),
        .d(LINK.din),
        .q(din_s),
        .rise(),
        .fall()
    );

    // ==========================================================
    // Internal gated shift clock events
    // ==========================================================
    logic frame;
    logic fall_ev;
    logic rise_ev;
    logic conv_start;
    logic [4:0] slot;
    logic [4:0] rises;
    logic [4:0] next_slot;

    assign frame = !cs_s;
    // Clock seen only inside a frame; a low resting clock turns the select fall into the first fall
    assign fall_ev = (cs_fall && !sclk_s) || (frame && sclk_fall); // RULE8 RULE9 RULE10
    assign rise_ev = frame && sclk_rise; // RULE8
    assign conv_start = fall_ev && (slot == 5'h00 || slot == adc_link_pkg::CONV_SLOTS); // RULE7
    assign next_slot = conv_start ? 5'h01 : slot + 5'h01;

    function automatic logic slot_bit(input logic [4:0] s, input logic [9:0] w);
        logic [4:0] idx;
        idx = adc_link_pkg::RES_LAST - s;
        if (s >= adc_link_pkg::RES_FIRST && s <= adc_link_pkg::RES_LAST) begin
            slot_bit = w[idx[3:0]]; // RULE3
        end else begin
            slot_bit = 1'b0; // RULE22
        end
    endfunction

    // ==========================================================
    // Slot and rise counters
    // ==========================================================
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            slot <= 5'h00;
        end else if (!frame) begin
            slot <= 5'h00;
        end else if (fall_ev) begin
            slot <= next_slot; // RULE1 RULE2 RULE7
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            rises <= 5'h00;
        end else if (!frame) begin
            rises <= 5'h00;
        end else if (conv_start) begin
            rises <= 5'h00;
        end else if (rise_ev && rises != adc_link_pkg::CONV_SLOTS) begin
            rises <= rises + 5'h01;
        end
    end

    // ==========================================================
    // Mode decode
    // ==========================================================
    assign TRACK = frame && slot != 5'h00 && slot <= adc_link_pkg::TRACK_LAST; // RULE1
    assign HOLD = frame && slot >= adc_link_pkg::HOLD_FIRST && slot < adc_link_pkg::CONV_SLOTS; // RULE2
    // Asleep outside frames and from the 16th fall to the next 1st fall
    assign POWER_DOWN = !frame || slot == 5'h00 || slot == adc_link_pkg::CONV_SLOTS; // RULE6

    // ==========================================================
    // Control word capture
    // ==========================================================
    logic [7:0] cw_shift;
    logic [7:0] next_word;
    logic pend_chan;

    assign next_word = {cw_shift[6:0], din_s};

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            cw_shift <= adc_link_pkg::CTRL_RESET;
        end else if (rise_ev && rises < adc_link_pkg::CTRL_RISES) begin
            cw_shift <= next_word; // RULE11
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            CTRL_WORD <= adc_link_pkg::CTRL_RESET;
            pend_chan <= adc_link_pkg::CHAN_RESET;
            ADDR_FAULT <= 1'b0;
        end else if (rise_ev && rises == adc_link_pkg::CTRL_RISES - 5'h01) begin
            CTRL_WORD <= next_word; // RULE11
            // Only the address field is looked at; the rest is don't-care
            pend_chan <= next_word[adc_link_pkg::CHAN_B0_POS]; // RULE13 RULE14 RULE15
            // Middle bit set gives an undefined result; flag it, keep using the low bit
            ADDR_FAULT <= next_word[adc_link_pkg::CHAN_B1_POS]; // RULE15
        end
    end

    // Pending code waits for the next track phase, never the running one
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            CHANNEL <= adc_link_pkg::CHAN_RESET; // RULE16
        end else if (conv_start) begin
            CHANNEL <= pend_chan; // RULE12
        end
    end

    // ==========================================================
    // Sample, convert and serial output
    // ==========================================================
    logic [9:0] held;
    logic [9:0] tracked;

    // Input code is used as the ideal straight-binary conversion
    assign tracked = CHANNEL ? ANALOG_B : ANALOG_A; // RULE18

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            held <= 10'h000;
        end else if (fall_ev && next_slot == adc_link_pkg::HOLD_FIRST) begin
            held <= tracked; // RULE2 RULE17
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            LINK.dout <= 1'b0;
        end else if (!frame) begin
            LINK.dout <= 1'b0;
        end else if (fall_ev) begin
            LINK.dout <= slot_bit(next_slot, held); // RULE20 RULE3 RULE22
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            LINK.dout_oe <= 1'b0;
        end else begin
            LINK.dout_oe <= frame; // RULE5
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            RESULT <= 10'h000;
            RESULT_VALID <= 1'b0;
        end else begin
            RESULT_VALID <= 1'b0;
            if (fall_ev && next_slot == adc_link_pkg::CONV_SLOTS) begin
                RESULT <= held; // RULE18
                RESULT_VALID <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Frame length check
    // ==========================================================
    // A frame must end on a whole conversion; stays until the next frame ends
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            FRAME_ERROR <= 1'b0;
        end else if (cs_rise) begin
            FRAME_ERROR <= rises != 5'h00 && rises != adc_link_pkg::CONV_SLOTS; // RULE4
        end
    end

endmodule
`default_nettype wire

// File: rtl/adc_frame_host.sv
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module adc_frame_host (
    input wire logic MCLK,
    input wire logic RST_N,
    adc_link_if.host LINK,
    input wire logic [3:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [15:0] RDATA
);

    typedef enum logic [4:0] {
        H_IDLE = 5'h01,
        H_LEAD = 5'h02,
        H_LOW = 5'h04,
        H_HIGH = 5'h08,
        H_TAIL = 5'h10
    } host_state_e;

    host_state_e state;
    logic [2:0] half;
    logic tick;
    logic [3:0] pos;
    logic [3:0] conv;
    logic [3:0] nconv;
    logic chan_req;
    logic prev_chan;
    logic [9:0] res_sh;
    logic [9:0] result;
    logic res_chan;
    logic res_valid;
    logic dout_s;
    logic [4:0] slot;
    logic [7:0] word;
    logic start;
    logic last_rise;
    logic rd_result;

    sync_edge #(.INIT(1'b1)) u_dout (
        .clk(MCLK),
        .rst_n(RST_N),
        .d(LINK.dout_seen),
        .q(dout_s),
        .rise(),
        .fall()
    );

    // ==========================================================
    // Register port
    // ==========================================================
    assign start = WR && ADDR == adc_link_pkg::REG_CTRL && WDATA[adc_link_pkg::CTRL_START_POS];
    assign rd_result = RD && ADDR == adc_link_pkg::REG_RESULT;

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            chan_req <= adc_link_pkg::CHAN_RESET;
            nconv <= 4'h0;
        end else if (WR && ADDR == adc_link_pkg::REG_CTRL && state == H_IDLE) begin
            chan_req <= WDATA[adc_link_pkg::CTRL_CHAN_POS];
            nconv <= WDATA[adc_link_pkg::CTRL_NCONV_LSB +: adc_link_pkg::NCONV_W];
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            RDATA <= 16'h0000;
        end else if (RD && ADDR == adc_link_pkg::REG_STATUS) begin
            RDATA <= {13'h0000, res_chan, res_valid, state != H_IDLE};
        end else if (rd_result) begin
            RDATA <= {6'h00, result};
        end else begin
            RDATA <= 16'h0000;
        end
    end

    // ==========================================================
    // Shift clock divider and frame sequencer
    // ==========================================================
    // 200 ns halves: 2.5 MHz, under the 8 MHz ceiling, and slow enough
    // for both synchroniser round trips before each sampling point
    assign tick = state != H_IDLE && half == 3'h0; // RULE21
    assign slot = {1'b0, pos} + 5'h01;
    assign last_rise = pos == 4'hf && conv == nconv;
    assign word = 8'(chan_req) << adc_link_pkg::CHAN_B0_POS; // RULE12 RULE15

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            half <= 3'h0;
        end else if (state == H_IDLE || tick) begin
            half <= adc_link_pkg::HALF_LAST;
        end else begin
            half <= half - 3'h1;
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            state <= H_IDLE;
        end else begin
            case (state)
                H_IDLE: begin
                    if (start) begin
                        state <= H_LEAD;
                    end
                end
                H_LEAD: begin
                    if (tick) begin
                        state <= H_LOW; // RULE19
                    end
                end
                H_LOW: begin
                    if (tick) begin
                        state <= H_HIGH;
                    end
                end
                H_HIGH: begin
                    if (tick) begin
                        state <= last_rise ? H_TAIL : H_LOW; // RULE4
                    end
                end
                H_TAIL: begin
                    if (tick) begin
                        state <= H_IDLE;
                    end
                end
                default: begin
                    state <= H_IDLE;
                end
            endcase
        end
    end

    // Clock rests high so the first fall is a real one, a half after select
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            LINK.cs_n <= 1'b1;
            LINK.sclk <= 1'b1;
        end else begin
            LINK.cs_n <= !(state == H_LEAD || state == H_LOW || state == H_HIGH || state == H_TAIL); // RULE4
            LINK.sclk <= state != H_LOW;
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            LINK.din <= 1'b0;
        end else if (state == H_IDLE) begin
            LINK.din <= 1'b0;
        end else if (state == H_LOW && half == adc_link_pkg::HALF_LAST) begin
            // Same edge as the clock fall, so the bit never moves while the clock is high
            LINK.din <= {1'b0, pos} < adc_link_pkg::CTRL_RISES ? word[3'(4'h7 - pos)] : 1'b0; // RULE11
        end
    end

    // ==========================================================
    // Result assembly
    // ==========================================================
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            pos <= 4'h0;
            conv <= 4'h0;
        end else if (state == H_IDLE) begin
            pos <= 4'h0;
            conv <= 4'h0;
        end else if (tick && state == H_HIGH) begin
            pos <= pos + 4'h1;
            if (pos == 4'hf) begin
                conv <= conv + 4'h1;
            end
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            res_sh <= 10'h000;
        end else if (tick && state == H_HIGH && slot >= adc_link_pkg::RES_FIRST && slot <= adc_link_pkg::RES_LAST) begin
            res_sh <= {res_sh[8:0], dout_s}; // RULE20 RULE23
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            result <= 10'h000;
            res_chan <= adc_link_pkg::CHAN_RESET;
            prev_chan <= adc_link_pkg::CHAN_RESET;
            res_valid <= 1'b0;
        end else begin
            if (tick && state == H_HIGH && pos == 4'hf) begin
                result <= res_sh; // RULE23
                res_chan <= prev_chan;
                prev_chan <= chan_req; // RULE12
                res_valid <= 1'b1;
            end else if (rd_result) begin
                res_valid <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// File: tb/adc_link_sva.sv
`timescale 1ns/10ps
`default_nettype none
module adc_link_sva (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    input wire logic dout_oe,
    input wire logic dout_seen
);
    logic [3:0] rises;
    logic sclk_q;

    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RST_N);

    // ==========================================================
    // Rise count within one conversion
    // ==========================================================
    // Wraps at 16, so each conversion of a long frame starts again at zero
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            rises <= 4'h0;
            sclk_q <= 1'b1;
        end else begin
            sclk_q <= sclk;
            if (cs_n) begin
                rises <= 4'h0;
            end else if (sclk && !sclk_q) begin
                rises <= rises + 4'h1;
            end
        end
    end

    // ==========================================================
    // Link properties
    // ==========================================================
    sequence s_low3;
        !sclk [*3];
    endsequence
    sequence s_high3;
        sclk [*3];
    endsequence
    property p_oe_on;
        $fell(cs_n) |-> ##[1:6] dout_oe;
    endproperty
    property p_oe_off;
        cs_n [*5] |-> !dout_oe;
    endproperty
    property p_oe_held;
        !cs_n [*5] |-> dout_oe;
    endproperty
    property p_lead_zero;
        $rose(sclk) && !cs_n && rises < 4'h4 |-> !dout_seen;
    endproperty
    property p_tail_zero;
        $rose(sclk) && !cs_n && rises > 4'hd |-> !dout_seen;
    endproperty
    property p_whole_frame;
        $rose(cs_n) |-> rises == 4'h0;
    endproperty
    property p_din_steady;
        !cs_n && sclk && $past(sclk) |-> $stable(din);
    endproperty
    property p_dout_steady;
        !cs_n && sclk && $past(sclk) && dout_oe && $past(dout_oe) |-> $stable(dout_seen);
    endproperty
    property p_low_half;
        $fell(sclk) |=> s_low3;
    endproperty
    property p_high_half;
        $rose(sclk) && !cs_n |=> s_high3;
    endproperty

    a_oe_on: assert property (p_oe_on) else $error("output not enabled in frame");
    a_oe_off: assert property (p_oe_off) else $error("output driven while deselected");
    a_oe_held: assert property (p_oe_held) else $error("output released in frame");
    a_lead_zero: assert property (p_lead_zero) else $error("leading slot not zero");
    a_tail_zero: assert property (p_tail_zero) else $error("trailing slot not zero");
    a_whole_frame: assert property (p_whole_frame) else $error("frame not a multiple of 16 rises");
    a_din_steady: assert property (p_din_steady) else $error("control bit moved while clock high");
    a_dout_steady: assert property (p_dout_steady) else $error("data moved while clock high");
    a_low_half: assert property (p_low_half) else $error("clock low half too short");
    a_high_half: assert property (p_high_half) else $error("clock high half too short");
endmodule
`default_nettype wire

// File: tb/dual_channel_adc_serial_frame_control_tb.sv
`timescale 1ns/10ps
`default_nettype none
module dual_channel_adc_serial_frame_control_tb;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] rdata;
    logic [9:0] ana_a = 10'h000;
    logic [9:0] ana_b = 10'h000;
    logic track, hold, power_down, channel, addr_fault, result_valid, frame_error;
    logic [7:0] ctrl_word;
    logic [9:0] result;
    logic [9:0] wire_word = 10'h000;
    logic [3:0] slot = 4'h0;
    logic sclk_seen = 1'b1;
    logic prev_code = 1'b0;
    int error_cnt, compares, pulses, cycles;

    always #25 mclk = ~mclk;

    adc_link_if link();
    adc_frame_host adc_frame_host_i (.MCLK(mclk), .RST_N(rst_n), .LINK(link), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata));
    adc_frame_device adc_frame_device_i (.MCLK(mclk), .RST_N(rst_n), .LINK(link), .ANALOG_A(ana_a),
        .ANALOG_B(ana_b), .TRACK(track), .HOLD(hold), .POWER_DOWN(power_down), .CHANNEL(channel),
        .CTRL_WORD(ctrl_word), .ADDR_FAULT(addr_fault), .RESULT(result), .RESULT_VALID(result_valid),
        .FRAME_ERROR(frame_error));
    adc_link_sva adc_link_sva_i (.MCLK(mclk), .RST_N(rst_n), .cs_n(link.cs_n), .sclk(link.sclk),
        .din(link.din), .dout_oe(link.dout_oe), .dout_seen(link.dout_seen));

    // ==========================================================
    // Checking and closing
    // ==========================================================
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ==========================================================
    // Register port access
    // ==========================================================
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        @(negedge mclk);
        d = rdata;
    endtask

    // ==========================================================
    // Link monitor
    // ==========================================================
    // Falling MCLK edge: flops of both ends have settled by then
    always @(negedge mclk) begin
        if (result_valid === 1'b1) begin
            pulses++;
        end
        if (link.cs_n !== 1'b0) begin
            slot = 4'h0;
        end else if (link.sclk === 1'b1 && sclk_seen === 1'b0) begin
            if (slot >= 4'h4 && slot <= 4'hd) begin
                wire_word = {wire_word[8:0], link.dout_seen};
            end
            if (slot == 4'h1) begin
                chk(track, 1'b1);
                chk(power_down, 1'b0);
            end
            if (slot == 4'h7) begin
                chk(hold, 1'b1);
            end
            slot = slot + 4'h1;
        end
        sclk_seen = link.sclk;
    end

    // One frame of nm1+1 conversions; the result comes from the code sent before when nm1 is zero, else from code
    task automatic conv(input logic code, input logic [3:0] nm1, input logic poke, input logic [9:0] a,
        input logic [9:0] b);
        logic [15:0] d;
        logic ch;
        logic [9:0] ev;
        int i;
        @(posedge mclk);
        ana_a <= a;
        ana_b <= b;
        ch = (nm1 != 4'h0) ? code : prev_code;
        ev = ch ? b : a;
        pulses = 0;
        wr_reg(adc_link_pkg::REG_CTRL, {10'h000, nm1, code, 1'b1});
        if (poke) begin
            // Refused while busy: a second start with the other code
            wr_reg(adc_link_pkg::REG_CTRL, {10'h000, 4'h0, ~code, 1'b1});
        end
        d = 16'h0001;
        for (i = 0; i < 4000 && d[0] !== 1'b0; i++) begin
            rd_reg(adc_link_pkg::REG_STATUS, d);
        end
        chk(d[2:0], {ch, 2'b10});
        chk(16'(pulses), {12'h000, nm1} + 16'h0001);
        rd_reg(adc_link_pkg::REG_RESULT, d);
        chk(d, {6'h00, ev});
        // Select rise takes two flops and one more before enable and error settle
        repeat (4) @(negedge mclk);
        chk(wire_word, ev);
        chk(result, ev);
        chk(ctrl_word[5:3], {2'b00, code});
        chk(addr_fault, 1'b0);
        chk(frame_error, 1'b0);
        chk(power_down, 1'b1);
        chk(link.dout_oe, 1'b0);
        rd_reg(adc_link_pkg::REG_STATUS, d);
        chk(d[1], 1'b0);
        prev_code = code;
    endtask

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        logic [15:0] d;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        chk(power_down, 1'b1);
        rd_reg(adc_link_pkg::REG_STATUS, d);
        chk(d, 16'h0000);
        rd_reg(4'h7, d);
        chk(d, 16'h0000);
        wr_reg(adc_link_pkg::REG_RESULT, 16'h0155);
        rd_reg(adc_link_pkg::REG_RESULT, d);
        chk(d, 16'h0000);
        conv(1'b0, 4'h0, 1'b0, 10'h3ff, 10'h155);
        conv(1'b1, 4'h0, 1'b1, 10'h000, 10'h3ff);
        conv(1'b1, 4'h2, 1'b0, 10'h0f0, 10'h2a5);
        conv(1'b0, 4'hf, 1'b0, 10'h1c3, 10'h2a5);
        final_report();
    end

    // Whole run needs about 2800 cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            final_report();
        end
    end
endmodule
`default_nettype wire
